// ==== include/fault_status_pkg.sv ====
// Constants of the fault status flag bank and its serial command target
// Function
// - Each status byte has its own command code, read or written one byte
// - Flags clear on the global clear command or on a written one
// - A flag whose cause is still active sets again at once
// - Output bit 7 latches on fixed or tracking overvoltage fault
// - Output bit 6 latches on tracking overvoltage warning
// - Output bit 5 latches on tracking undervoltage warning
// - Output bit 4 latches on tracking undervoltage fault
// - Unsupported bits read zero and ignore writes
// - Current bit 7 latches on valley current limit; read-only to writes
// - Current bit 6 latches on current limit with undervoltage fault
// - Input bit 7 latches on supply overvoltage fault
// - Input bit 4 latches on supply undervoltage fault
// - Input bit 0 latches on input overpower event
// - All flags reset to zero
// - Overpower compares power telemetry to a 3-bit selected threshold
package fault_status_pkg;

  // Command codes of the three status bytes and of the global clear
  localparam logic [7:0] CMD_OUTPUT_STATUS = 8'h7a;
  localparam logic [7:0] CMD_CURRENT_STATUS = 8'h7b;
  localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
  localparam logic [7:0] CMD_CLEAR_ALL = 8'h03;

  // Seven-bit bus address of this target
  localparam logic [6:0] TARGET_ADDR = 7'h24;

  // Register indices inside the bank
  localparam int NUM_REGS = 3;
  localparam logic [1:0] IDX_OUTPUT = 2'h0;
  localparam logic [1:0] IDX_CURRENT = 2'h1;
  localparam logic [1:0] IDX_INPUT = 2'h2;
  localparam logic [1:0] IDX_NONE = 2'h3;

  // Flag positions
  localparam int BIT_OUT_OV_FAULT = 7;
  localparam int BIT_OUT_OV_WARN = 6;
  localparam int BIT_OUT_UV_WARN = 5;
  localparam int BIT_OUT_UV_FAULT = 4;
  localparam int BIT_CUR_VALLEY = 7;
  localparam int BIT_CUR_WITH_UV = 6;
  localparam int BIT_IN_OV_FAULT = 7;
  localparam int BIT_IN_UV_FAULT = 4;
  localparam int BIT_IN_POWER = 0;

  // Supported flag masks, index order output, current, input
  localparam logic [2:0][7:0] SUPPORTED_MASK = {8'h91, 8'hc0, 8'hf0};
  // Positions a written one may clear
  localparam logic [2:0][7:0] WRITE_CLEAR_MASK = {8'h91, 8'h40, 8'hf0};
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // Input power thresholds in watts, indexed by the select code
  localparam int POWER_W = 10;
  localparam logic [7:0][9:0] POWER_LIMIT_W = {
    10'd120, 10'd180, 10'd240, 10'd300,
    10'd360, 10'd420, 10'd480, 10'd510};

  // Synchroniser depth for pins and detector levels
  localparam int SYNC_STAGES = 2;

endpackage

// ==== include/flag_access_if.sv ====
// Access path between the serial command engine and the flag bank
interface flag_access_if;
  logic [7:0] cmd;
  logic wr_en;
  logic [7:0] wr_data;
  logic clear_all;
  logic [7:0] rd_data;

  modport engine (
    output cmd,
    output wr_en,
    output wr_data,
    output clear_all,
    input rd_data
  );

  modport bank (
    input cmd,
    input wr_en,
    input wr_data,
    input clear_all,
    output rd_data
  );
endinterface

// ==== rtl/fault_status_flag_bank.sv ====
// Fault status flag bank with its two-wire byte command target
module fault_status_flag_bank (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Two-wire bus pins; data is open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Fault detector levels, asynchronous to the system clock
  input wire logic i_out_fixed_ov_fault,
  input wire logic i_out_track_ov_fault,
  input wire logic i_out_track_ov_warn,
  input wire logic i_out_track_uv_warn,
  input wire logic i_out_track_uv_fault,
  input wire logic i_valley_current_limit,
  input wire logic i_supply_ov_fault,
  input wire logic i_supply_uv_fault,
  // Input power telemetry and threshold, same clock domain
  input wire logic [9:0] i_input_power,
  input wire logic [2:0] i_input_power_threshold_select
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_CMD = 4'h3,
    ST_CMD_ACK = 4'h4,
    ST_DATA = 4'h5,
    ST_DATA_ACK = 4'h6,
    ST_TX = 4'h7,
    ST_TX_ACK = 4'h8,
    ST_IGNORE = 4'h9
  } bus_state_t;

  localparam int NUM_DET = 8;

  flag_access_if acc ();

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [NUM_DET-1:0] det_meta_q;
  logic [NUM_DET-1:0] det_q;
  logic [NUM_DET-1:0] det_raw;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  bus_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic rw_q;
  logic [7:0] cmd_q;
  logic cmd_seen_q;
  logic data_seen_q;
  logic wr_en_q;
  logic [7:0] wr_data_q;
  logic clear_q;
  logic sda_oe_q;
  logic sda_out_q;
  logic power_over;
  logic [2:0][7:0] set_vec;

  // Threshold lookup for the overpower comparator
  function automatic logic [9:0] power_limit(input logic [2:0] code);
    power_limit = fault_status_pkg::POWER_LIMIT_W[code];
  endfunction

  assign det_raw = {i_out_fixed_ov_fault, i_out_track_ov_fault,
    i_out_track_ov_warn, i_out_track_uv_warn, i_out_track_uv_fault,
    i_valley_current_limit, i_supply_ov_fault, i_supply_uv_fault};

  // Detector levels cross into the clock domain through two flops
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      det_meta_q <= '0;
      det_q <= '0;
    end
    else
    begin
      det_meta_q <= det_raw;
      det_q <= det_meta_q;
    end
  end

  // Pin synchronisers plus one history flop for edge finding
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], i_scl};
      sda_sync_q <= {sda_sync_q[0], i_sda};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  assign scl_rise = scl_sync_q[1] && !scl_prev_q;
  assign scl_fall = !scl_sync_q[1] && scl_prev_q;
  // Data edges while the clock stays high mark frame boundaries
  assign bus_start = scl_sync_q[1] && scl_prev_q
    && sda_prev_q && !sda_sync_q[1];
  assign bus_stop = scl_sync_q[1] && scl_prev_q
    && !sda_prev_q && sda_sync_q[1];

  // Byte-level command engine: address, command code, one data byte
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      cmd_q <= 8'h00;
      cmd_seen_q <= 1'b0;
      data_seen_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_data_q <= 8'h00;
      clear_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      wr_en_q <= 1'b0;
      clear_q <= 1'b0;
      if (bus_start)
      begin
        // Repeated start keeps the command code for a following read
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        cmd_seen_q <= 1'b0;
        data_seen_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end
      else if (bus_stop)
      begin
        // Clear-all is a command code with no data byte behind it
        if (cmd_seen_q && !data_seen_q
          && cmd_q == fault_status_pkg::CMD_CLEAR_ALL)
          clear_q <= 1'b1;
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          ST_IDLE, ST_IGNORE:
            sda_oe_q <= 1'b0;
          ST_ADDR, ST_CMD, ST_DATA:
          begin
            if (scl_rise && bit_cnt_q != 4'h8)
            begin
              shift_q <= {shift_q[6:0], sda_sync_q[1]};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (scl_fall && bit_cnt_q == 4'h8)
            begin
              bit_cnt_q <= 4'h0;
              if (state_q == ST_ADDR)
              begin
                if (shift_q[7:1] == fault_status_pkg::TARGET_ADDR)
                begin
                  rw_q <= shift_q[0];
                  sda_oe_q <= 1'b1;
                  state_q <= ST_ADDR_ACK;
                end
                else
                  state_q <= ST_IGNORE;
              end
              else if (state_q == ST_CMD)
              begin
                cmd_q <= shift_q;
                cmd_seen_q <= 1'b1;
                sda_oe_q <= 1'b1;
                state_q <= ST_CMD_ACK;
              end
              else
              begin
                // Single-byte write reaches the selected status byte
                wr_en_q <= 1'b1;
                wr_data_q <= shift_q;
                data_seen_q <= 1'b1;
                sda_oe_q <= 1'b1;
                state_q <= ST_DATA_ACK;
              end
            end
          end
          ST_ADDR_ACK, ST_CMD_ACK, ST_DATA_ACK, ST_TX_ACK:
          begin
            if (scl_rise && state_q == ST_TX_ACK && sda_sync_q[1])
              state_q <= ST_IGNORE;
            else if (scl_fall)
            begin
              if ((state_q == ST_ADDR_ACK && rw_q)
                || state_q == ST_TX_ACK)
              begin
                // Read byte sampled here; later flag changes wait
                shift_q <= acc.rd_data;
                sda_oe_q <= ~acc.rd_data[7];
                bit_cnt_q <= 4'h1;
                state_q <= ST_TX;
              end
              else
              begin
                sda_oe_q <= 1'b0;
                // Bytes beyond the first data byte are not acknowledged
                state_q <= (state_q == ST_ADDR_ACK) ? ST_CMD
                  : (state_q == ST_CMD_ACK) ? ST_DATA : ST_IGNORE;
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt_q == 4'h8)
              begin
                sda_oe_q <= 1'b0;
                state_q <= ST_TX_ACK;
              end
              else
              begin
                sda_oe_q <= ~shift_q[6];
                shift_q <= {shift_q[6:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Data pin only ever pulls low
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rstn)
      sda_out_q <= 1'b0;
    else
      sda_out_q <= 1'b0;
  end

  assign o_sda_out = sda_out_q;
  assign o_sda_oe = sda_oe_q;

  assign acc.cmd = cmd_q;
  assign acc.wr_en = wr_en_q;
  assign acc.wr_data = wr_data_q;
  assign acc.clear_all = clear_q;

  // Strict greater-than: telemetry equal to the limit is not an event
  assign power_over = i_input_power
    > power_limit(i_input_power_threshold_select);

  // Set terms are live levels, so a persisting cause re-sets a flag
  always_comb
  begin
    set_vec = '0;
    set_vec[fault_status_pkg::IDX_OUTPUT][fault_status_pkg::BIT_OUT_OV_FAULT]
      = det_q[7] | det_q[6];
    set_vec[fault_status_pkg::IDX_OUTPUT][fault_status_pkg::BIT_OUT_OV_WARN]
      = det_q[5];
    set_vec[fault_status_pkg::IDX_OUTPUT][fault_status_pkg::BIT_OUT_UV_WARN]
      = det_q[4];
    set_vec[fault_status_pkg::IDX_OUTPUT][fault_status_pkg::BIT_OUT_UV_FAULT]
      = det_q[3];
    set_vec[fault_status_pkg::IDX_CURRENT][fault_status_pkg::BIT_CUR_VALLEY]
      = det_q[2];
    set_vec[fault_status_pkg::IDX_CURRENT][fault_status_pkg::BIT_CUR_WITH_UV]
      = det_q[2] & det_q[3];
    set_vec[fault_status_pkg::IDX_INPUT][fault_status_pkg::BIT_IN_OV_FAULT]
      = det_q[1];
    set_vec[fault_status_pkg::IDX_INPUT][fault_status_pkg::BIT_IN_UV_FAULT]
      = det_q[0];
    set_vec[fault_status_pkg::IDX_INPUT][fault_status_pkg::BIT_IN_POWER]
      = power_over;
  end

  status_flag_store u_store (
    .i_clk_sys (i_clk_sys),
    .i_rstn (i_rstn),
    .i_set (set_vec),
    .acc (acc.bank)
  );

endmodule

// ==== rtl/status_flag_store.sv ====
// Storage of the three latched status bytes with write-one-to-clear
module status_flag_store (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Set requests per register, one byte each
  input wire logic [2:0][7:0] i_set,
  // Access path
  flag_access_if.bank acc
);

  logic [2:0][7:0] flags_q;
  logic [1:0] sel_idx;

  // Command code to bank index
  function automatic logic [1:0] reg_index(input logic [7:0] code);
    unique case (code)
      fault_status_pkg::CMD_OUTPUT_STATUS:
        reg_index = fault_status_pkg::IDX_OUTPUT;
      fault_status_pkg::CMD_CURRENT_STATUS:
        reg_index = fault_status_pkg::IDX_CURRENT;
      fault_status_pkg::CMD_INPUT_STATUS:
        reg_index = fault_status_pkg::IDX_INPUT;
      default: reg_index = fault_status_pkg::IDX_NONE;
    endcase
  endfunction

  assign sel_idx = reg_index(acc.cmd);

  // One flag byte per register; set term is ORed after the clear
  for (genvar i = 0; i < fault_status_pkg::NUM_REGS; i++)
  begin : g_reg
    logic [7:0] clr;
    logic hit;
    assign hit = acc.wr_en && (sel_idx == 2'(i));
    // Read-only and zero positions are masked out of the written-one clear; clear-all reaches every bit
    assign clr = {8{acc.clear_all}}
      | ({8{hit}} & acc.wr_data
      & fault_status_pkg::WRITE_CLEAR_MASK[i]);
    always_ff @(posedge i_clk_sys)
    begin
      if (!i_rstn)
        flags_q[i] <= fault_status_pkg::FLAG_RESET;
      else
        flags_q[i] <= ((flags_q[i] & ~clr) | i_set[i])
          & fault_status_pkg::SUPPORTED_MASK[i];
    end
  end

  // Read mux; unknown codes answer zero
  always_comb
  begin
    if (sel_idx == fault_status_pkg::IDX_NONE)
      acc.rd_data = 8'h00;
    else
      acc.rd_data = flags_q[sel_idx];
  end

endmodule

// ==== verification/fault_status_flag_bank_checker.sv ====
// Port assertions on the bus pins of the fault status flag bank
module fault_status_flag_bank_checker (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // Bus pins
  input wire logic i_scl,
  input wire logic o_sda_out,
  input wire logic o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain; nothing is judged while reset is held
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  a_open_drain_only: assert property (!o_sda_out)
    else $error("data pin driven high");
  a_reset_quiet: assert property ($rose(i_rstn) |-> !o_sda_oe [*2])
    else $error("data pulled right after reset");
  // Drive moves in the clock low phase, after the synchroniser delay
  a_pull_at_low: assert property (
    $rose(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("pull began with the clock high");
  a_release_at_low: assert property ($fell(o_sda_oe) |-> !i_scl)
    else $error("pull ended with the clock high");
  a_pull_whole_bit: assert property ($rose(o_sda_oe) |-> o_sda_oe [*5])
    else $error("pull shorter than one bit");
  a_stable_scl_high: assert property (
    i_scl && $past(i_scl) && $past(i_scl, 2) |-> $stable(o_sda_oe))
    else $error("drive moved while the clock was high");
  a_idle_released: assert property (i_scl [*8] |-> !o_sda_oe)
    else $error("data pulled on an idle bus");
  a_change_after_fall: assert property (
    $changed(o_sda_oe) |-> $past(i_scl, 3) || $past(i_scl, 4) ||
    $past(i_scl, 5) || $past(i_scl, 6))
    else $error("drive moved with no recent clock fall");
endmodule

// ==== verification/fault_status_flag_bank_tb.sv ====
// Self-checking bench for the fault status flag bank
module fault_status_flag_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ADDR_W = {fault_status_pkg::TARGET_ADDR, 1'b0};
  logic clk, rstn, scl, pull, oe, sdo, ok;
  wire sda;
  logic [7:0] det, rd;
  logic [9:0] pwr;
  logic [2:0] sel;
  logic [7:0] wmask[3] = '{8'hf0, 8'h40, 8'h91};
  logic [7:0] cmds[3] = '{8'h7a, 8'h7b, 8'h7c};
  int flags[3];
  int err_total, comparisons, cycles, r;
  // Open drain with pull-up: low while either side pulls
  assign sda = !(oe | pull);
  // System clock at 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  fault_status_flag_bank i_dut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sdo), .o_sda_oe(oe),
    .i_out_fixed_ov_fault(det[0]), .i_out_track_ov_fault(det[1]),
    .i_out_track_ov_warn(det[2]), .i_out_track_uv_warn(det[3]),
    .i_out_track_uv_fault(det[4]), .i_valley_current_limit(det[5]),
    .i_supply_ov_fault(det[6]), .i_supply_uv_fault(det[7]),
    .i_input_power(pwr), .i_input_power_threshold_select(sel));
  two_wire_host_model i_host (
    .i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
  task automatic chk(input string name, input logic [7:0] exp,
    input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic int lim();
    return (sel == 3'h0) ? 510 : 540 - 60 * int'(sel);
  endfunction
  // Flags the present causes force on; a set outlives any clear
  function automatic int cause(int k);
    case (k)
      0: return {det[0] | det[1], det[2], det[3], det[4], 4'h0};
      1: return {det[5], det[5] & det[4], 6'h00};
      default: return {det[6], 2'h0, det[7], 3'h0, pwr > lim()};
    endcase
  endfunction
  // Hold causes past the synchronisers, then latch them in the model
  task automatic apply();
    repeat (6) @(posedge clk);
    #1;
    for (int k = 0; k < 3; k++)
      flags[k] |= cause(k);
  endtask
  task automatic rd_reg(input int k);
    i_host.xfer(ADDR_W, cmds[k], 8'h00, 2, rd, ok);
    chk("ack", 1'b1, ok);
    chk("status", flags[k][7:0], rd);
  endtask
  task automatic rd_all();
    for (int k = 0; k < 3; k++)
      rd_reg(k);
  endtask
  task automatic wr_reg(input int k, input logic [7:0] d);
    i_host.xfer(ADDR_W, cmds[k], d, 0, rd, ok);
    chk("ack", 1'b1, ok);
    flags[k] = (flags[k] & ~(d & wmask[k])) | cause(k);
  endtask
  task automatic clr_all();
    i_host.xfer(ADDR_W, fault_status_pkg::CMD_CLEAR_ALL, 8'h00, 1, rd, ok);
    chk("ack", 1'b1, ok);
    for (int k = 0; k < 3; k++)
      flags[k] = cause(k);
  endtask
  // Reset, each cause alone, random traffic, refusals, reset again
  initial
  begin
    rstn = 1'b0;
    det = 8'h00;
    pwr = 10'h000;
    sel = 3'h0;
    void'($urandom(32'ha3ba));
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rd_all();
    for (int b = 0; b < 9; b++)
    begin
      det = 8'h01 << b;
      pwr = (b == 8) ? 10'h1ff : 10'h000;
      apply();
      det = 8'h00;
      pwr = 10'h000;
      for (int k = 0; k < 3; k++)
      begin
        wr_reg(k, 8'h00);
        rd_reg(k);
        wr_reg(k, 8'hff);
        rd_reg(k);
      end
    end
    clr_all();
    repeat (12)
    begin
      det = 8'($urandom_range(0, 255) & $urandom_range(0, 255));
      sel = 3'($urandom_range(0, 7));
      pwr = 10'(lim() + $urandom_range(0, 2) - 1);
      apply();
      r = $urandom_range(0, 2);
      rd_reg(r);
      if ($urandom_range(0, 1) == 1)
        wr_reg(r, 8'($urandom_range(0, 255)));
      else
        clr_all();
      det = 8'h00;
      pwr = 10'h000;
      apply();
      rd_all();
    end
    i_host.xfer(ADDR_W ^ 8'h02, cmds[0], 8'hff, 0, rd, ok);
    chk("foreign ack", 1'b0, ok);
    i_host.xfer(ADDR_W, 8'h7d, 8'hff, 0, rd, ok);
    chk("unknown ack", 1'b1, ok);
    i_host.xfer(ADDR_W, 8'h7d, 8'h00, 2, rd, ok);
    chk("unknown cmd", 8'h00, rd);
    rd_all();
    // Host acknowledge after a read byte brings the same byte again
    i_host.xfer(ADDR_W, cmds[2], 8'h00, 3, rd, ok);
    chk("resend ack", 1'b1, ok);
    chk("resend", flags[2][7:0], rd);
    det = 8'hff;
    apply();
    det = 8'h00;
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    flags = '{0, 0, 0};
    repeat (4) @(posedge clk);
    #1;
    rd_all();
    conclude();
  end
  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      err_total++;
      conclude();
    end
  end
endmodule
bind fault_status_flag_bank fault_status_flag_bank_checker i_chk (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_scl(i_scl),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe));

// ==== verification/two_wire_host_model.sv ====
// Behavioural two-wire host reading, writing and clearing status bytes
module two_wire_host_model (
  // System clock paces the bus
  input wire logic i_clk_sys,
  // Resolved data wire
  input wire logic i_sda,
  // Bus clock and data pull-down
  output logic o_scl,
  output logic o_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: nothing pulled, clock standing high
  initial
  begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end
  // Quarter bit of two system clocks; pins move just after an edge
  task automatic step(input logic c, input logic p);
    o_scl = c;
    o_pull = p;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  // A one releases the line so the target may answer
  task automatic bit_io(input logic b, output logic s);
    step(1'b0, !b);
    step(1'b1, !b);
    s = i_sda;
    step(1'b1, !b);
    step(1'b0, !b);
  endtask
  // Eight bits MSB first, then a released ninth; low there is an ack
  task automatic byte_io(input logic [7:0] b, output logic [7:0] s,
    output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s[i]);
    bit_io(1'b1, a);
    ack = !a;
  endtask
  // Kind 0 write byte, 1 command alone, 2 read byte via repeated start,
  // 3 read with the first byte acknowledged so the target sends it again
  task automatic xfer(input logic [7:0] a, input logic [7:0] cmd,
    input logic [7:0] data, input int kind, output logic [7:0] rd,
    output logic ok);
    logic [7:0] s;
    logic k1, k2, k3, kx;
    rd = 8'h00;
    k3 = 1'b1;
    step(o_scl, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    byte_io(a, s, k1);
    byte_io(cmd, s, k2);
    if (kind == 0)
      byte_io(data, s, k3);
    if (kind >= 2)
    begin
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      byte_io(a | 8'h01, s, k3);
      if (kind == 3)
      begin
        // Host pulls the ninth bit low to ask for the byte once more
        for (int i = 7; i >= 0; i--)
          bit_io(1'b1, s[i]);
        bit_io(1'b0, kx);
      end
      byte_io(8'hff, rd, kx);
    end
    // Stop: data rises while the clock is high
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    ok = k1 & k2 & k3;
    // Both copies of a resent byte must agree
    if (kind == 3)
      ok = ok & (s == rd);
  endtask
endmodule
